/* core/sdx_pkg.sv */
// Purpose: shared constants and types for both ends of the sdram command link
// Assumes: one 100 MHz clock, four banks, commands decoded from ras/cas/we
// Notes: least times round up to whole cycles
package sdx_pkg;
   localparam int NUM_BANKS = 4;
   localparam int BA_W = 2;
   localparam int ADDR_W = 11;
   localparam int AP_BIT = 10;
   localparam int COL_W = 4;
   localparam int DQ_W = 32;
   localparam int CAS_LAT = 2;
   localparam int BURST_LEN = 4;
   localparam int DQM_LEAD = 2;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W = 5;
   localparam int CLK_NS = 10;
   localparam int T_RCD_NS = 20;
   localparam int T_RP_NS = 20;
   localparam int T_WR_NS = 15;
   localparam int T_XSR_NS = 80;
   localparam int T_MRD_NS = 20;
   localparam int TRCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
   localparam int TRP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
   localparam int TWR_CYC = (T_WR_NS + CLK_NS - 1) / CLK_NS;
   localparam int TXSR_CYC = (T_XSR_NS + CLK_NS - 1) / CLK_NS;
   localparam int TMRD_CYC = (T_MRD_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [CNT_W-1:0] RCD_LD = CNT_W'(TRCD_CYC - 1);
   localparam logic [CNT_W-1:0] RP_LD = CNT_W'(TRP_CYC - 1);
   // full tWR: the recovery state hands over to precharging one edge late
   localparam logic [CNT_W-1:0] WR_LD = CNT_W'(TWR_CYC);
   localparam logic [CNT_W-1:0] XSR_LD = CNT_W'(TXSR_CYC);
   localparam logic [CNT_W-1:0] MRD_LD = CNT_W'(TMRD_CYC);
   localparam logic [CNT_W-1:0] INIT_LD = CNT_W'(TXSR_CYC + 2);
   localparam logic [CNT_W-1:0] DQM_LD = CNT_W'(DQM_LEAD - 1);
   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
   localparam logic [ADDR_W-1:0] AP_MASK = 11'h400;
   typedef logic [2:0] sdx_cmd_t;   // {ras_n, cas_n, we_n}
   localparam sdx_cmd_t CMD_MRS = 3'h0;
   localparam sdx_cmd_t CMD_REF = 3'h1;
   localparam sdx_cmd_t CMD_PRE = 3'h2;
   localparam sdx_cmd_t CMD_ACT = 3'h3;
   localparam sdx_cmd_t CMD_WR = 3'h4;
   localparam sdx_cmd_t CMD_RD = 3'h5;
   localparam sdx_cmd_t CMD_BST = 3'h6;
   localparam sdx_cmd_t CMD_NOP = 3'h7;
   typedef enum logic [3:0] {
      BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
      BK_READ_AP, BK_WRITE_AP, BK_WR_RECOVER, BK_PRECHARGING
   } sdx_bank_e;
   typedef enum logic [2:0] {
      CT_INIT, CT_IDLE, CT_ACT, CT_DQM, CT_WAIT
   } sdx_ctrl_e;
endpackage : sdx_pkg

/* core/sdx_if.sv */
// Purpose: pin-level link between controller and memory device
// Assumes: both ends share i_clock; dq resolved here from the two enables
// Notes: an undriven dq reads as zero
`timescale 1ns/1ps
`default_nettype none
interface sdx_if;
   import sdx_pkg::*;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [BA_W-1:0] ba;
   logic [ADDR_W-1:0] addr;
   logic dqm;
   logic [DQ_W-1:0] ctrl_dq_o;
   logic ctrl_dq_oe;
   logic [DQ_W-1:0] dev_dq_o;
   logic dev_dq_oe;
   logic [DQ_W-1:0] dq;
   assign dq = ctrl_dq_oe ? ctrl_dq_o : (dev_dq_oe ? dev_dq_o : '0);
   modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
                output dev_dq_o, dev_dq_oe);
   modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm,
                 output ctrl_dq_o, ctrl_dq_oe, input dq);
endinterface : sdx_if
`default_nettype wire

/* core/sdx_device.sv */
// Purpose: memory-side bank tracking and cross-bank command acceptance
// Assumes: commands sampled on every rising edge of i_clock
// Notes: small array stands in for the cell array; refresh is accepted only
`timescale 1ns/1ps
`default_nettype none
module sdx_device
   import sdx_pkg::*;
#(
   parameter int P_BURST_LEN = BURST_LEN, // beats per burst
   parameter int P_CAS_LAT = CAS_LAT      // read latency, at least 2
) (
   input wire logic i_clock,              // system clock
   input wire logic i_rst,                // async reset, high
   sdx_if.dev lk,                         // command and data pins
   output logic o_all_idle,               // every bank idle
   output logic o_illegal,                // refused command seen
   output logic [NUM_BANKS-1:0] o_bank_open // bank not idle
);
   localparam int PL = P_CAS_LAT - 1;
   localparam int MW = BA_W + COL_W;
   localparam logic [CNT_W-1:0] BL_LD = CNT_W'(P_BURST_LEN - 1);

   logic cke_prev_reg;
   logic [CNT_W-1:0] xsr_reg;
   logic en;
   logic sel;
   sdx_cmd_t cmd;
   logic is_act;
   logic is_rd;
   logic is_wr;
   logic is_pre;
   logic is_bst;
   logic is_ref;
   logic is_mrs;
   logic pre_all;
   logic ok;
   logic acc_rw;
   logic kill;
   logic [CNT_W-1:0] rem_reg;
   logic [CNT_W-1:0] rem_next;
   logic [BA_W-1:0] own_reg;
   logic [BA_W-1:0] own_next;
   logic wr_reg;
   logic [COL_W-1:0] col_reg;
   logic beat_v;
   logic beat_wr;
   logic [MW-1:0] beat_a;
   logic [DQ_W-1:0] mem [2**MW];
   logic [PL-1:0] rv_reg;
   logic [MW-1:0] ra_reg [PL];
   logic [DQ_W-1:0] dq_o_reg;
   logic dq_oe_reg;
   sdx_bank_e st_reg [NUM_BANKS];
   logic [NUM_BANKS-1:0] idle_v;
   logic [NUM_BANKS-1:0] rw_ok_v;
   logic [NUM_BANKS-1:0] pre_ok_v;
   logic [NUM_BANKS-1:0] ap_v;
   logic [NUM_BANKS-1:0] live_v;

   // exit timer restarts whenever cke rises, covering self refresh exit
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cke_prev_reg <= 1'b0;
         xsr_reg <= '0;
      end else begin
         cke_prev_reg <= lk.cke;
         if (lk.cke && !cke_prev_reg) begin
            xsr_reg <= XSR_LD;
         end else if (xsr_reg != '0) begin
            xsr_reg <= xsr_reg - CNT_ONE;
         end
      end
   end

   assign en = lk.cke & cke_prev_reg & (xsr_reg == '0);
   assign sel = en & ~lk.cs_n;
   assign cmd = {lk.ras_n, lk.cas_n, lk.we_n};
   assign is_act = sel & (cmd == CMD_ACT);
   assign is_rd = sel & (cmd == CMD_RD);
   assign is_wr = sel & (cmd == CMD_WR);
   assign is_pre = sel & (cmd == CMD_PRE);
   assign is_bst = sel & (cmd == CMD_BST);
   assign is_ref = sel & (cmd == CMD_REF);
   assign is_mrs = sel & (cmd == CMD_MRS);
   assign pre_all = lk.addr[AP_BIT];

   // listed commands are refused and flagged when bank state forbids them; anything else passes
   always_comb begin
      ok = 1'b1;
      if (is_act) begin
         ok = idle_v[lk.ba];
      end else if (is_rd || is_wr) begin
         ok = rw_ok_v[lk.ba];
      end else if (is_pre) begin
         ok = pre_all ? (&pre_ok_v) : pre_ok_v[lk.ba];
      end else if (is_bst) begin
         ok = (rem_reg != '0) & ~ap_v[own_reg];
      end else if (is_ref || is_mrs) begin
         ok = &idle_v;
      end
   end

   assign acc_rw = (is_rd | is_wr) & ok;
   // a precharge to another bank does not stop the running burst
   assign kill = ok & (is_bst | (is_pre & (pre_all | (lk.ba == own_reg))));

   always_comb begin
      rem_next = (rem_reg == '0) ? '0 : rem_reg - CNT_ONE;
      own_next = own_reg;
      if (acc_rw) begin
         rem_next = BL_LD;
         own_next = lk.ba;
      end else if (kill) begin
         rem_next = '0;
      end
   end

   // the new command's beat replaces the old burst's beat in the same cycle
   assign beat_v = acc_rw | ((rem_reg != '0) & ~kill);
   assign beat_wr = acc_rw ? is_wr : wr_reg;
   assign beat_a = acc_rw ? {lk.ba, lk.addr[COL_W-1:0]} : {own_reg, col_reg};

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         rem_reg <= '0;
         own_reg <= '0;
         wr_reg <= 1'b0;
         col_reg <= '0;
      end else begin
         rem_reg <= rem_next;
         own_reg <= own_next;
         if (acc_rw) begin
            wr_reg <= is_wr;
         end
         if (beat_v) begin
            col_reg <= beat_a[COL_W-1:0] + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (beat_v && beat_wr && !lk.dqm) begin
         mem[beat_a] <= lk.dq;
      end
   end

   // read pipe; dqm travels with each beat so masked beats never drive
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         rv_reg <= '0;
      end else begin
         rv_reg[0] <= beat_v & ~beat_wr & ~lk.dqm;
         for (int i = 1; i < PL; i++) begin
            rv_reg[i] <= rv_reg[i-1];
         end
         if (acc_rw && is_wr) begin
            rv_reg <= '0;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      ra_reg[0] <= beat_a;
      for (int i = 1; i < PL; i++) begin
         ra_reg[i] <= ra_reg[i-1];
      end
   end

   // older read data keeps flowing until the new read's data takes over
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         dq_o_reg <= '0;
         dq_oe_reg <= 1'b0;
      end else begin
         dq_o_reg <= mem[ra_reg[PL-1]];
         dq_oe_reg <= rv_reg[PL-1] & ~(acc_rw & is_wr);
      end
   end

   assign lk.dev_dq_o = dq_o_reg;
   assign lk.dev_dq_oe = dq_oe_reg;

   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      logic hit;
      logic [CNT_W-1:0] cnt_reg;
      sdx_bank_e s;
      assign s = st_reg[b];
      assign hit = (lk.ba == BA_W'(b));
      assign idle_v[b] = (s == BK_IDLE);
      assign rw_ok_v[b] = (s == BK_ACTIVE) | (s == BK_READ) | (s == BK_WRITE);
      assign pre_ok_v[b] = rw_ok_v[b] | idle_v[b] | (s == BK_PRECHARGING);
      assign ap_v[b] = (s == BK_READ_AP) | (s == BK_WRITE_AP);
      assign live_v[b] = (own_next == BA_W'(b)) & (rem_next != '0);

      always_ff @(posedge i_clock or posedge i_rst) begin
         if (i_rst) begin
            st_reg[b] <= BK_IDLE;
            cnt_reg <= '0;
         end else begin
            case (s)
               BK_IDLE: begin
                  if (is_act && ok && hit) begin
                     st_reg[b] <= BK_ACTIVATING;
                     cnt_reg <= RCD_LD;
                  end
               end
               BK_ACTIVATING: begin
                  if (cnt_reg <= CNT_ONE) begin
                     st_reg[b] <= BK_ACTIVE;
                  end else begin
                     cnt_reg <= cnt_reg - CNT_ONE;
                  end
               end
               BK_ACTIVE, BK_READ, BK_WRITE: begin
                  if (acc_rw && hit) begin
                     if (lk.addr[AP_BIT]) begin
                        st_reg[b] <= is_wr ? BK_WRITE_AP : BK_READ_AP;
                     end else begin
                        st_reg[b] <= is_wr ? BK_WRITE : BK_READ;
                     end
                  end else if (is_pre && ok && (hit || pre_all)) begin
                     st_reg[b] <= BK_PRECHARGING;
                     cnt_reg <= RP_LD;
                  end else if (s != BK_ACTIVE && !live_v[b]) begin
                     st_reg[b] <= BK_ACTIVE;
                  end
               end
               BK_READ_AP: begin
                  if (!live_v[b]) begin
                     st_reg[b] <= BK_PRECHARGING;
                     cnt_reg <= RP_LD;
                  end
               end
               BK_WRITE_AP: begin
                  if (!live_v[b]) begin
                     st_reg[b] <= BK_WR_RECOVER;
                     cnt_reg <= WR_LD;
                  end
               end
               BK_WR_RECOVER: begin
                  if (cnt_reg <= CNT_ONE) begin
                     st_reg[b] <= BK_PRECHARGING;
                     cnt_reg <= RP_LD;
                  end else begin
                     cnt_reg <= cnt_reg - CNT_ONE;
                  end
               end
               BK_PRECHARGING: begin
                  if (cnt_reg <= CNT_ONE) begin
                     st_reg[b] <= BK_IDLE;
                  end else begin
                     cnt_reg <= cnt_reg - CNT_ONE;
                  end
               end
               default: begin
                  st_reg[b] <= BK_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_all_idle <= 1'b1;
         o_illegal <= 1'b0;
         o_bank_open <= '0;
      end else begin
         o_all_idle <= &idle_v;
         o_illegal <= sel & ~ok;
         o_bank_open <= ~idle_v;
      end
   end
endmodule : sdx_device
`default_nettype wire

/* core/sdx_ctrl.sv */
// Purpose: controller end; queues requests and issues legal command runs
// Assumes: request depth is a power of two; same burst length as the device
// Notes: one word per request, other beats masked; always auto precharge
`timescale 1ns/1ps
`default_nettype none
module sdx_fifo
   import sdx_pkg::*;
#(
   parameter int P_WIDTH = DQ_W,        // word width
   parameter int P_DEPTH = FIFO_DEPTH   // entries
) (
   input wire logic i_clock,            // system clock
   input wire logic i_rst,              // async reset, high
   input wire logic i_in_valid,         // push request
   output logic o_in_ready,             // room for a word
   input wire logic [P_WIDTH-1:0] i_in_data, // pushed word
   output logic o_out_valid,            // word available
   input wire logic i_out_ready,        // pop request
   output logic [P_WIDTH-1:0] o_out_data // head word
);
   localparam int AW = $clog2(P_DEPTH);
   localparam int CW = AW + 1;
   logic [P_WIDTH-1:0] mem [P_DEPTH];
   logic [AW-1:0] wp_reg;
   logic [AW-1:0] rp_reg;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic push;
   logic pop;

   assign push = i_in_valid & o_in_ready;
   assign pop = i_out_ready & o_out_valid;
   assign cnt_next = cnt_reg + CW'(push) - CW'(pop);
   assign o_out_data = mem[rp_reg];

   always_ff @(posedge i_clock) begin
      if (push) begin
         mem[wp_reg] <= i_in_data;
      end
   end

   // flags registered from the next count so they are exact every cycle
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
         o_in_ready <= 1'b1;
         o_out_valid <= 1'b0;
      end else begin
         if (push) begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= rp_reg + 1'b1;
         end
         cnt_reg <= cnt_next;
         o_in_ready <= (cnt_next != CW'(P_DEPTH));
         o_out_valid <= (cnt_next != '0);
      end
   end
endmodule : sdx_fifo

module sdx_ctrl
   import sdx_pkg::*;
#(
   parameter int P_BURST_LEN = BURST_LEN, // beats per burst
   parameter int P_CAS_LAT = CAS_LAT      // read latency
) (
   input wire logic i_clock,              // system clock
   input wire logic i_rst,                // async reset, high
   sdx_if.ctrl lk,                        // command and data pins
   input wire logic i_req_valid,          // request offered
   output logic o_req_ready,              // request queue has room
   input wire logic i_req_write,          // 1 write, 0 read
   input wire logic [BA_W-1:0] i_req_bank, // bank
   input wire logic [ADDR_W-1:0] i_req_row, // row
   input wire logic [COL_W-1:0] i_req_col, // column
   input wire logic [DQ_W-1:0] i_req_data, // write word
   output logic o_rd_valid,               // read word pulse
   output logic [DQ_W-1:0] o_rd_data,     // read word
   output logic o_busy                    // command run in progress
);
   localparam int RW = 1 + BA_W + ADDR_W + COL_W + DQ_W;
   localparam logic [CNT_W-1:0] DONE_LD = CNT_W'(P_BURST_LEN + TWR_CYC + TRP_CYC);
   localparam logic [CNT_W-1:0] CAP_LD = CNT_W'(P_CAS_LAT + 1);

   logic [RW-1:0] q;
   logic q_valid;
   logic q_wr;
   logic pop;
   logic go_rd;
   logic go_wr;
   sdx_ctrl_e st_reg;
   logic [CNT_W-1:0] wt_reg;
   logic [CNT_W-1:0] cap_reg;
   logic cke_reg;
   logic cs_n_reg;
   sdx_cmd_t cmd_reg;
   logic [BA_W-1:0] ba_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic dqm_reg;
   logic [DQ_W-1:0] dq_o_reg;
   logic dq_oe_reg;

   sdx_fifo #(.P_WIDTH(RW), .P_DEPTH(FIFO_DEPTH)) u_req (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_in_valid(i_req_valid),
      .o_in_ready(o_req_ready),
      .i_in_data({i_req_write, i_req_bank, i_req_row, i_req_col, i_req_data}),
      .o_out_valid(q_valid),
      .i_out_ready(pop),
      .o_out_data(q)
   );

   assign q_wr = q[RW-1];
   assign go_rd = (st_reg == CT_ACT) & (wt_reg == '0) & ~q_wr;
   assign go_wr = (st_reg == CT_DQM) & (wt_reg == '0);
   assign pop = go_rd | go_wr;

   // one bank at a time, always auto precharge: only legal sequences arise
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= CT_INIT;
         wt_reg <= INIT_LD;
         cke_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         cmd_reg <= CMD_NOP;
         ba_reg <= '0;
         addr_reg <= '0;
         dqm_reg <= 1'b1;
         dq_o_reg <= '0;
         dq_oe_reg <= 1'b0;
      end else begin
         cke_reg <= 1'b1;
         cs_n_reg <= 1'b1;
         cmd_reg <= CMD_NOP;
         dqm_reg <= 1'b1;
         dq_oe_reg <= 1'b0;
         if (wt_reg != '0) begin
            wt_reg <= wt_reg - CNT_ONE;
         end
         case (st_reg)
            CT_INIT: begin
               if (wt_reg == '0) begin
                  cs_n_reg <= 1'b0;
                  cmd_reg <= CMD_MRS;
                  addr_reg <= '0;
                  wt_reg <= MRD_LD;
                  st_reg <= CT_IDLE;
               end
            end
            CT_IDLE: begin
               if (wt_reg == '0 && q_valid) begin
                  cs_n_reg <= 1'b0;
                  cmd_reg <= CMD_ACT;
                  ba_reg <= q[RW-2 -: BA_W];
                  addr_reg <= q[DQ_W+COL_W +: ADDR_W];
                  wt_reg <= RCD_LD;
                  st_reg <= CT_ACT;
               end
            end
            CT_ACT: begin
               if (wt_reg == '0) begin
                  if (q_wr) begin
                     wt_reg <= DQM_LD;
                     st_reg <= CT_DQM;
                  end else begin
                     cs_n_reg <= 1'b0;
                     cmd_reg <= CMD_RD;
                     addr_reg <= AP_MASK | ADDR_W'(q[DQ_W +: COL_W]);
                     dqm_reg <= 1'b0;
                     wt_reg <= DONE_LD;
                     st_reg <= CT_WAIT;
                  end
               end
            end
            CT_DQM: begin
               if (wt_reg == '0) begin
                  cs_n_reg <= 1'b0;
                  cmd_reg <= CMD_WR;
                  addr_reg <= AP_MASK | ADDR_W'(q[DQ_W +: COL_W]);
                  dqm_reg <= 1'b0;
                  dq_o_reg <= q[DQ_W-1:0];
                  dq_oe_reg <= 1'b1;
                  wt_reg <= DONE_LD;
                  st_reg <= CT_WAIT;
               end
            end
            CT_WAIT: begin
               // covers burst, write recovery and the auto precharge
               if (wt_reg == '0) begin
                  st_reg <= CT_IDLE;
               end
            end
            default: begin
               st_reg <= CT_IDLE;
            end
         endcase
      end
   end

   assign lk.cke = cke_reg;
   assign lk.cs_n = cs_n_reg;
   assign {lk.ras_n, lk.cas_n, lk.we_n} = cmd_reg;
   assign lk.ba = ba_reg;
   assign lk.addr = addr_reg;
   assign lk.dqm = dqm_reg;
   assign lk.ctrl_dq_o = dq_o_reg;
   assign lk.ctrl_dq_oe = dq_oe_reg;

   // read word is sampled cas latency after the device takes the read
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cap_reg <= '0;
         o_rd_valid <= 1'b0;
         o_rd_data <= '0;
         o_busy <= 1'b0;
      end else begin
         if (go_rd) begin
            cap_reg <= CAP_LD;
         end else if (cap_reg != '0) begin
            cap_reg <= cap_reg - CNT_ONE;
         end
         o_rd_valid <= (cap_reg == CNT_ONE);
         if (cap_reg == CNT_ONE) begin
            o_rd_data <= lk.dq;
         end
         o_busy <= (st_reg != CT_IDLE);
      end
   end
endmodule : sdx_ctrl
`default_nettype wire

/* testbench/sdx_link_sva.sv */
// Purpose: pin checks on the link between controller and device
// Assumes: one clock domain; both ends are design code
// Notes: sees only the link, not bank state
`timescale 1ns/1ps
`default_nettype none
module sdx_link_sva
   import sdx_pkg::*;
(
   input wire logic i_clock, // clock
   input wire logic i_rst, // reset
   input wire logic cke, // clock enable
   input wire logic cs_n, // select
   input wire logic ras_n, // row strobe
   input wire logic cas_n, // column strobe
   input wire logic we_n, // write enable
   input wire logic [ADDR_W-1:0] addr, // address
   input wire logic dqm, // mask
   input wire logic ctrl_dq_oe, // controller drive
   input wire logic dev_dq_oe // device drive
);
   wire logic [2:0] cmd = {ras_n, cas_n, we_n};
   wire logic sel = cke && !cs_n;
   wire logic rd = sel && cmd == CMD_RD;
   wire logic wr = sel && cmd == CMD_WR;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   property p_no_clash;
      !(ctrl_dq_oe && dev_dq_oe);
   endproperty
   a_no_clash: assert property (p_no_clash) else $error("dq driven by both");
   property p_dqm_lead;
      wr |-> $past(dqm, 1) && $past(dqm, 2);
   endproperty
   a_dqm_lead: assert property (p_dqm_lead) else $error("mask lead short");
   property p_wr_beat;
      wr |-> (ctrl_dq_oe && !dqm) ##1 (!ctrl_dq_oe && dqm);
   endproperty
   a_wr_beat: assert property (p_wr_beat) else $error("write beat wrong");
   property p_rd_data;
      rd |-> ##2 dev_dq_oe;
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("read data late");
   property p_cke_hold;
      cke |=> cke;
   endproperty
   a_cke_hold: assert property (p_cke_hold) else $error("clock enable dropped");
   property p_xsr_quiet;
      $rose(cke) |-> (cs_n || cmd == CMD_NOP) [*8];
   endproperty
   a_xsr_quiet: assert property (p_xsr_quiet) else $error("command before exit");
   property p_no_bst;
      !(sel && cmd == CMD_BST);
   endproperty
   a_no_bst: assert property (p_no_bst) else $error("burst stop issued");
   property p_ap_on;
      (rd || wr) |-> addr[AP_BIT];
   endproperty
   a_ap_on: assert property (p_ap_on) else $error("access without autoclose");
endmodule : sdx_link_sva
`default_nettype wire

/* testbench/sdram_cross_bank_command_rules_tb_top.sv */
// Purpose: queue traffic through the link, raw commands to a second device
// Assumes: delays as handed over by the designer
// Notes: the raw link breaks controller habits on purpose
`timescale 1ns/1ps
`default_nettype none
module sdram_cross_bank_command_rules_tb_top;
   import sdx_pkg::*;
   logic i_clock;
   logic i_rst;
   logic req_valid, req_ready, req_write, rd_valid, ill_a, ill_b, idle_b, busy;
   logic [BA_W-1:0] req_bank;
   logic [ADDR_W-1:0] req_row;
   logic [COL_W-1:0] req_col;
   logic [DQ_W-1:0] req_data, rd_data;
   logic [NUM_BANKS-1:0] open_b;
   logic seen_full = 1'b0;
   logic [DQ_W-1:0] exp_q[$];
   int num_errors = 0;
   int total_checks = 0;
   int ill_cnt_a = 0;
   int ill_cnt_b = 0;
   int cnt0;
   logic [3:0] bad[5] = '{4'h3, 4'h1, 4'h0, 4'h6, 4'hb};
   sdx_if lk();
   sdx_if lk2();
   sdx_ctrl u_sdx_ctrl (.i_clock(i_clock), .i_rst(i_rst), .lk(lk.ctrl), .i_req_valid(req_valid),
      .o_req_ready(req_ready), .i_req_write(req_write), .i_req_bank(req_bank),
      .i_req_row(req_row), .i_req_col(req_col), .i_req_data(req_data),
      .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_busy(busy));
   sdx_device u_sdx_device (.i_clock(i_clock), .i_rst(i_rst), .lk(lk.dev), .o_all_idle(),
      .o_illegal(ill_a), .o_bank_open());
   sdx_device u_sdx_device_b (.i_clock(i_clock), .i_rst(i_rst), .lk(lk2.dev),
      .o_all_idle(idle_b), .o_illegal(ill_b), .o_bank_open(open_b));
   sdx_link_sva u_sdx_link_sva (.i_clock(i_clock), .i_rst(i_rst), .cke(lk.cke), .cs_n(lk.cs_n),
      .ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n), .addr(lk.addr), .dqm(lk.dqm),
      .ctrl_dq_oe(lk.ctrl_dq_oe), .dev_dq_oe(lk.dev_dq_oe));
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   // one request, held until the queue takes it
   task automatic push(input logic wr, input int k);
      @(negedge i_clock);
      req_valid = 1'b1;
      req_write = wr;
      req_bank = 2'(k);
      req_row = 11'h055;
      req_col = 4'(k + 1);
      req_data = 32'ha5a5_0000 + 32'(k);
      do @(posedge i_clock); while (req_ready !== 1'b1);
      if (!wr) exp_q.push_back(req_data);
      @(negedge i_clock);
      req_valid = 1'b0;
   endtask : push
   // c is {cs_n, ras_n, cas_n, we_n}, held for one rising edge
   task automatic raw(input logic [3:0] c, input logic [1:0] b, input logic [10:0] a);
      @(negedge i_clock);
      {lk2.cs_n, lk2.ras_n, lk2.cas_n, lk2.we_n} = c;
      lk2.ba = b;
      lk2.addr = a;
   endtask : raw
   always @(posedge i_clock) begin
      if (rd_valid === 1'b1) check("read word", rd_data, exp_q.pop_front());
      if (req_valid && req_ready === 1'b0) seen_full <= 1'b1;
      if (ill_a === 1'b1) ill_cnt_a++;
      if (ill_b === 1'b1) ill_cnt_b++;
   end
   initial begin
      repeat (5000) @(posedge i_clock);
      num_errors++;
      tally_and_finish();
   end
   initial begin
      i_rst = 1'b1;
      {req_valid, req_write, req_bank, req_row, req_col, req_data} = '0;
      {lk2.cke, lk2.cs_n, lk2.ras_n, lk2.cas_n, lk2.we_n, lk2.dqm, lk2.ctrl_dq_oe} = 7'h1e;
      lk2.ba = '0;
      lk2.addr = '0;
      lk2.ctrl_dq_o = '0;
      repeat (10) @(posedge i_clock);
      @(negedge i_clock);
      i_rst = 1'b0;
      lk2.cke = 1'b1;
      check("idle after reset", 32'(idle_b), 32'h0000_0001);
      for (int b = 0; b < 4; b++) push(1'b1, b);
      // reads outpace service, so the queue must fill and refuse
      for (int i = 0; i < 20; i++) push(1'b0, i % 4);
      for (int t = 0; t < 600 && exp_q.size() > 0; t++) @(posedge i_clock);
      check("reads left", 32'(exp_q.size()), 32'h0000_0000);
      check("queue full seen", 32'(seen_full), 32'h0000_0001);
      check("link refusals", 32'(ill_cnt_a), 32'h0000_0000);
      raw(4'h3, 2'd0, 11'h055);
      raw(4'h3, 2'd1, 11'h055);
      // open flags are registered, so the second activate shows one edge later
      repeat (2) raw(4'h7, 2'd0, 11'h000);
      check("banks opening", 32'(open_b), 32'h0000_0003);
      raw(4'h5, 2'd0, 11'h400);
      raw(4'h5, 2'd1, 11'h000);
      repeat (4) raw(4'h7, 2'd0, 11'h000);
      check("early autoclose", 32'(open_b), 32'h0000_0002);
      repeat (2) raw(4'h7, 2'd0, 11'h000);
      cnt0 = ill_cnt_b;
      foreach (bad[i]) begin
         raw(bad[i], 2'd1, 11'h000);
         raw(4'h7, 2'd0, 11'h000);
      end
      raw(4'h7, 2'd0, 11'h000);
      check("refused count", 32'(ill_cnt_b - cnt0), 32'h0000_0004);
      raw(4'h2, 2'd1, 11'h000);
      repeat (3) raw(4'h7, 2'd0, 11'h000);
      raw(4'h1, 2'd0, 11'h000);
      repeat (2) raw(4'h7, 2'd0, 11'h000);
      check("legal refresh", 32'(ill_cnt_b - cnt0), 32'h0000_0004);
      check("all idle", 32'(idle_b), 32'h0000_0001);
      // autoclosing write on bank 0 cut by a read on bank 1: recovery, then precharge
      raw(4'h3, 2'd0, 11'h055);
      raw(4'h3, 2'd1, 11'h055);
      raw(4'h4, 2'd0, 11'h400);
      raw(4'h5, 2'd1, 11'h000);
      repeat (4) raw(4'h7, 2'd0, 11'h000);
      check("write recovery held", 32'(open_b), 32'h0000_0003);
      raw(4'h7, 2'd0, 11'h000);
      check("recovered bank idle", 32'(open_b), 32'h0000_0002);
      // precharge to the other bank must leave the burst alive for a stop
      raw(4'h5, 2'd1, 11'h000);
      raw(4'h2, 2'd0, 11'h000);
      raw(4'h6, 2'd0, 11'h000);
      repeat (2) raw(4'h7, 2'd0, 11'h000);
      check("burst past precharge", 32'(ill_cnt_b - cnt0), 32'h0000_0004);
      check("controller idle", 32'(busy), 32'h0000_0000);
      tally_and_finish();
   end
endmodule : sdram_cross_bank_command_rules_tb_top
`default_nettype wire
